//--- verilog/smrfd_top.sv
// sector map descriptor rom and factory default state behind apb
// assumes an apb master on pclk; all apb inputs are pclk-synchronous
// Behaviour
// - the map header reports region count 00h and configuration id 05h.
// - the header low byte has bits 7:2 set, the map bit and the end bit.
// - region size field is 00ffffh for 128 mb and 01ffffh for 256 mb.
// - the size msb is 00h or 01h by density and the other bytes read ffh.
// - erase support bits read 1111_0100 for the 256 kb region.
// - the main array reads erased, ffh in every byte.
// - the otp region holds random bytes in its first 16 and ffh elsewhere.
// - status one and configuration one and three copies hold 00h.
// - the configuration two copy holds 08h.
// - the configuration four copy holds 10h.
// - every password bit reads one.
// - the protection register reads ffffh and all lock bits are one.
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module smrfd_top
  import smrfd_pkg::*;
#(
  parameter bit DENSITY_256 = 1'b0,
  parameter int LOCK_WORDS = 4,
  parameter int OTP_WORDS = 256,
  // arbitrary value standing for the per-part random otp content
  parameter logic [127:0] OTP_RANDOM = 128'h0123456789abcdef0fedcba987654321
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] nv_cfg_ff;
  logic [7:0] nv_cr4_ff;
  logic [31:0] vol_cfg_ff;
  logic [7:0] vol_cr4_ff;
  logic [7:0] idx_ff;
  logic done_ff;
  smrfd_state_t state_ff;
  logic [LOCK_WORDS*32-1:0] lock_bits_ff;
  logic [31:0] nxt_rdata;
  logic nxt_err;
  logic wr_fire;
  logic acc;

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  // first access cycle and a completing write transfer without error
  assign acc = psel && penable && !pready_ff;
  assign wr_fire = psel && penable && pready_ff && pwrite && !pslverr_ff;

  ////////////////////////////////////////////////////////////////////////
  // fixed descriptor words
  function automatic logic [31:0] map_hdr_word();
    map_hdr_word = {MAP_RFU_HI, MAP_REGION_CNT, MAP_CONFIG_ID,
                    MAP_RFU_LO, MAP_DESC_BIT, MAP_END_BIT};
  endfunction

  function automatic logic [31:0] map_region_word();
    logic [23:0] size;
    size = DENSITY_256 ? REGION_SIZE_256 : REGION_SIZE_128;
    map_region_word = {size, ERASE_RFU, ERASE_TYPES};
  endfunction

  // otp word: random head then erased
  function automatic logic [31:0] otp_word(input logic [7:0] idx);
    otp_word = ERASED_WORD;
    if (idx < 8'(OTP_RANDOM_WORDS)) begin
      otp_word = OTP_RANDOM[idx[1:0]*32 +: 32];
    end
  endfunction

  // byte-lane merge for writable words
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] st);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = st[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // read mux and decode
  always_comb begin
    nxt_rdata = 32'h0;
    nxt_err = 1'b0;
    case (paddr)
      OFS_MAP_HDR: nxt_rdata = map_hdr_word();
      OFS_MAP_REGION: nxt_rdata = map_region_word();
      OFS_NV_CFG: nxt_rdata = nv_cfg_ff;
      OFS_NV_CR4: nxt_rdata = {24'h0, nv_cr4_ff};
      OFS_VOL_CFG: nxt_rdata = vol_cfg_ff;
      OFS_VOL_CR4: nxt_rdata = {24'h0, vol_cr4_ff};
      OFS_CTRL: nxt_rdata = 32'h0;
      OFS_STATUS: nxt_rdata = {31'h0, done_ff};
      OFS_PASS_LO: nxt_rdata = ERASED_WORD;
      OFS_PASS_HI: nxt_rdata = ERASED_WORD;
      OFS_PROT: nxt_rdata = {16'h0, DEF_PROT};
      OFS_LOCK_DATA: begin
        if (idx_ff < 8'(LOCK_WORDS)) begin
          nxt_rdata = lock_bits_ff[idx_ff*32 +: 32];
        end
      end
      OFS_IDX: nxt_rdata = {24'h0, idx_ff};
      OFS_OTP_DATA: begin
        if (idx_ff < 8'(OTP_WORDS - 1) || idx_ff == 8'(OTP_WORDS - 1)) begin
          nxt_rdata = otp_word(idx_ff);
        end
      end
      OFS_ARRAY_DATA: nxt_rdata = ERASED_WORD;
      default: nxt_err = 1'b1;
    endcase
    // read-only words refuse writes
    if (pwrite && !(paddr == OFS_NV_CFG || paddr == OFS_NV_CR4 ||
        paddr == OFS_CTRL || paddr == OFS_IDX)) begin
      nxt_err = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb answer: one wait state, then ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      pready_ff <= acc;
      pslverr_ff <= acc ? nxt_err : 1'b0;
      if (acc) begin
        prdata_ff <= pwrite ? 32'h0 : nxt_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // non-volatile copies, delivered with factory values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_cfg_ff <= {DEF_CR3, DEF_CR2, DEF_CR1, DEF_SR1};
      nv_cr4_ff <= DEF_CR4;
    end else if (wr_fire && paddr == OFS_NV_CFG) begin
      nv_cfg_ff <= merge(nv_cfg_ff, pwdata, pstrb);
    end else if (wr_fire && paddr == OFS_NV_CR4 && pstrb[0]) begin
      nv_cr4_ff <= pwdata[7:0];
    end
  end

  // index for otp and lock word windows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_ff <= 8'h0;
    end else if (wr_fire && paddr == OFS_IDX && pstrb[0]) begin
      idx_ff <= pwdata[7:0];
    end
  end

  // lock bits, all set at delivery
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_bits_ff <= '1;
    end else begin
      lock_bits_ff <= lock_bits_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // load sequencer: copy nv into volatile after reset or reload
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_LOAD;
      done_ff <= 1'b0;
      vol_cfg_ff <= 32'h0;
      vol_cr4_ff <= 8'h0;
    end else begin
      case (state_ff)
        ST_LOAD: begin
          vol_cfg_ff <= nv_cfg_ff;
          vol_cr4_ff <= nv_cr4_ff;
          done_ff <= 1'b1;
          state_ff <= ST_RUN;
        end
        ST_RUN: begin
          if (wr_fire && paddr == OFS_CTRL && pstrb[0] &&
              pwdata[CTRL_RELOAD_BIT]) begin
            done_ff <= 1'b0;
            state_ff <= ST_LOAD;
          end
        end
        default: state_ff <= ST_LOAD;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  // transfer phases as seen at the slave
  sequence rd_done(logic [7:0] a);
    psel && penable && pready_ff && !pwrite && paddr == a;
  endsequence

  sequence reset_release;
    !$past(presetn) && presetn;
  endsequence

  sequence wr_done(logic [7:0] a);
    psel && penable && pready_ff && pwrite && paddr == a && !pslverr_ff;
  endsequence

  sequence access_start;
    psel && penable && !pready_ff;
  endsequence

  map_id_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_done(OFS_MAP_HDR) |-> prdata_ff[23:16] == MAP_REGION_CNT &&
      prdata_ff[15:8] == MAP_CONFIG_ID && !pslverr_ff)
    else $error("map header id wrong");

  map_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_done(OFS_MAP_HDR) |-> prdata_ff[7:0] == 8'hff)
    else $error("map header low byte wrong");

  region_size_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    rd_done(OFS_MAP_REGION) |-> prdata_ff[31:8] ==
      (DENSITY_256 ? REGION_SIZE_256 : REGION_SIZE_128))
    else $error("region size wrong");

  size_bytes_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    rd_done(OFS_MAP_REGION) |-> prdata_ff[31:24] == {7'h0, DENSITY_256}
      && prdata_ff[23:8] == 16'hffff)
    else $error("region size bytes wrong");

  erase_bits_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    rd_done(OFS_MAP_REGION) |-> prdata_ff[7:0] == 8'hf4)
    else $error("erase support bits wrong");

  array_erased_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    rd_done(OFS_ARRAY_DATA) |-> prdata_ff == ERASED_WORD)
    else $error("array not erased");

  otp_tail_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_done(OFS_OTP_DATA) ##0 idx_ff >= 8'(OTP_RANDOM_WORDS) |->
      prdata_ff == ERASED_WORD)
    else $error("otp tail not erased");

  nv_low_a: assert property (@(posedge pclk)
    reset_release |-> nv_cfg_ff[7:0] == DEF_SR1 &&
      nv_cfg_ff[15:8] == DEF_CR1 && nv_cfg_ff[31:24] == DEF_CR3)
    else $error("status one or config one three default wrong");

  nv_cr2_a: assert property (@(posedge pclk)
    reset_release |-> nv_cfg_ff[23:16] == DEF_CR2)
    else $error("config two default wrong");

  nv_cr4_a: assert property (@(posedge pclk)
    reset_release |-> nv_cr4_ff == DEF_CR4)
    else $error("config four default wrong");

  password_ones_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    (rd_done(OFS_PASS_LO) or rd_done(OFS_PASS_HI)) |->
      prdata_ff == ERASED_WORD)
    else $error("password not all ones");

  prot_reg_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_done(OFS_PROT) |-> prdata_ff[15:0] == DEF_PROT && &lock_bits_ff)
    else $error("protection or lock bits wrong");

  vol_load_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    state_ff == ST_LOAD |=> done_ff && vol_cfg_ff == $past(nv_cfg_ff)
      && vol_cr4_ff == $past(nv_cr4_ff))
    else $error("volatile load missed");

  ////////////////////////////////////////////////////////////////////////
  // bus protocol checks: one wait state, one-cycle answer
  ready_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    access_start |=> pready_ff)
    else $error("ready not one cycle after access start");

  ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready_ff |=> !pready_ff)
    else $error("ready held longer than one cycle");

  err_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr_ff |-> pready_ff && prdata_ff == 32'h0)
    else $error("error without ready or with data");

  ro_write_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pready_ff && pwrite &&
      (paddr == OFS_MAP_HDR || paddr == OFS_PROT) |-> pslverr_ff)
    else $error("write to read-only word not refused");

  // idle answer lines at the first edge out of reset
  rst_idle_a: assert property (@(posedge pclk)
    reset_release |-> !pready_ff && !pslverr_ff && prdata_ff == 32'h0)
    else $error("answer lines busy after reset");

  ////////////////////////////////////////////////////////////////////////
  // write side and window checks
  cr4_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_done(OFS_NV_CR4) ##0 pstrb[0] |=> nv_cr4_ff == $past(pwdata[7:0]))
    else $error("config four copy write lost");

  cr4_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_done(OFS_NV_CR4) ##0 !pstrb[0] |=> $stable(nv_cr4_ff))
    else $error("config four copy changed without lane zero");

  idx_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_done(OFS_IDX) ##0 pstrb[0] |=> idx_ff == $past(pwdata[7:0]))
    else $error("window index write lost");

  reload_pulse_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    wr_done(OFS_CTRL) ##0 pstrb[0] && pwdata[CTRL_RELOAD_BIT] |=>
      !done_ff ##1 done_ff)
    else $error("reload did not run");

  otp_head_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_done(OFS_OTP_DATA) ##0 idx_ff < 8'(OTP_RANDOM_WORDS) |->
      prdata_ff == OTP_RANDOM[idx_ff[1:0]*32 +: 32])
    else $error("otp random head wrong");

  lock_window_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    rd_done(OFS_LOCK_DATA) ##0 idx_ff < 8'(LOCK_WORDS) |->
      prdata_ff == ERASED_WORD)
    else $error("lock word not all ones");

endmodule

//--- verilog/smrfd_pkg.sv
// package for the sector map rom and factory default block
// assumes a single apb clock domain and 32-bit register words
package smrfd_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFS_MAP_HDR = 8'h00;
  localparam logic [7:0] OFS_MAP_REGION = 8'h04;
  localparam logic [7:0] OFS_NV_CFG = 8'h08;
  localparam logic [7:0] OFS_NV_CR4 = 8'h0c;
  localparam logic [7:0] OFS_VOL_CFG = 8'h10;
  localparam logic [7:0] OFS_VOL_CR4 = 8'h14;
  localparam logic [7:0] OFS_CTRL = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_PASS_LO = 8'h20;
  localparam logic [7:0] OFS_PASS_HI = 8'h24;
  localparam logic [7:0] OFS_PROT = 8'h28;
  localparam logic [7:0] OFS_LOCK_DATA = 8'h2c;
  localparam logic [7:0] OFS_IDX = 8'h30;
  localparam logic [7:0] OFS_OTP_DATA = 8'h34;
  localparam logic [7:0] OFS_ARRAY_DATA = 8'h38;

  ////////////////////////////////////////////////////////////////////////
  // sector map configuration five
  localparam logic [7:0] MAP_RFU_HI = 8'hff;
  localparam logic [7:0] MAP_REGION_CNT = 8'h00;
  localparam logic [7:0] MAP_CONFIG_ID = 8'h05;
  localparam logic [5:0] MAP_RFU_LO = 6'h3f;
  localparam logic MAP_DESC_BIT = 1'b1;
  localparam logic MAP_END_BIT = 1'b1;
  localparam logic [23:0] REGION_SIZE_128 = 24'h00ffff;
  localparam logic [23:0] REGION_SIZE_256 = 24'h01ffff;
  localparam logic [3:0] ERASE_RFU = 4'hf;
  localparam logic [3:0] ERASE_TYPES = 4'h4;

  ////////////////////////////////////////////////////////////////////////
  // factory delivery values
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [31:0] ERASED_WORD = 32'hffffffff;
  localparam logic [7:0] DEF_SR1 = 8'h00;
  localparam logic [7:0] DEF_CR1 = 8'h00;
  localparam logic [7:0] DEF_CR2 = 8'h08;
  localparam logic [7:0] DEF_CR3 = 8'h00;
  localparam logic [7:0] DEF_CR4 = 8'h10;
  localparam logic [15:0] DEF_PROT = 16'hffff;
  localparam int OTP_RANDOM_BYTES = 16;
  localparam int OTP_RANDOM_WORDS = OTP_RANDOM_BYTES / 4;
  localparam int CTRL_RELOAD_BIT = 0;
  localparam int STATUS_DONE_BIT = 0;

  // load sequencer states
  typedef enum logic [0:0] {ST_LOAD, ST_RUN} smrfd_state_t;

endpackage

//--- sim/smrfd_host.sv
// apb host model reading and writing the default-state registers
// assumes calls start right after a rising pclk edge
`timescale 1ns/1ps
module smrfd_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // bus idle at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // one transfer: setup, access held until pready, then one idle edge
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, input logic [3:0] st,
                      output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata; // taken at the completing edge
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
endmodule

//--- sim/sector_map_rom_and_factory_defaults_bench.sv
// self-checking bench for the sector map rom and factory defaults
// assumes the apb host model in smrfd_host.sv, 256 mb density
`timescale 1ns/1ps
module sector_map_rom_and_factory_defaults_bench;
  import smrfd_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  int fail_count = 0;
  int tests_run = 0;
  // arbitrary stand-in for the per-part random otp head
  localparam logic [127:0] OTP_HEAD = 128'h3c5a7e91b2d4f60818293a4b5c6d7e8f;

  // 25 mhz clock
  always #20 pclk = ~pclk;

  smrfd_top #(.DENSITY_256(1'b1), .OTP_RANDOM(OTP_HEAD)) smrfd_top_inst (
    .pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  smrfd_host smrfd_host_inst (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  ////////////////////////////////////////////////////////////////////////
  // compare and bus helpers
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // single-bit answer flags
  task automatic chk_err(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t flag got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                        input logic experr);
    logic [31:0] d;
    logic e;
    smrfd_host_inst.xfer(1'b0, a, 32'h0, 4'h0, d, e);
    chk32(d, exp);
    chk_err(e, experr);
  endtask

  task automatic wr_lane_chk(input logic [7:0] a, input logic [31:0] wd,
                             input logic [3:0] st, input logic experr);
    logic [31:0] d;
    logic e;
    smrfd_host_inst.xfer(1'b1, a, wd, st, d, e);
    chk_err(e, experr);
  endtask

  task automatic wr_chk(input logic [7:0] a, input logic [31:0] wd,
                        input logic experr);
    wr_lane_chk(a, wd, 4'hf, experr);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic test_map;
    rd_chk(OFS_MAP_HDR, 32'hff0005ff, 1'b0);
    rd_chk(OFS_MAP_REGION, 32'h01fffff4, 1'b0);
  endtask

  task automatic test_defaults;
    rd_chk(OFS_NV_CFG, 32'h00080000, 1'b0);
    rd_chk(OFS_NV_CR4, 32'h00000010, 1'b0);
    rd_chk(OFS_VOL_CFG, 32'h00080000, 1'b0);
    rd_chk(OFS_VOL_CR4, 32'h00000010, 1'b0);
    rd_chk(OFS_STATUS, 32'h00000001, 1'b0);
    rd_chk(OFS_PASS_LO, 32'hffffffff, 1'b0);
    rd_chk(OFS_PASS_HI, 32'hffffffff, 1'b0);
    rd_chk(OFS_PROT, 32'h0000ffff, 1'b0);
    rd_chk(OFS_ARRAY_DATA, 32'hffffffff, 1'b0);
  endtask

  task automatic test_windows;
    for (int i = 0; i <= 4; i++) begin
      wr_chk(OFS_IDX, 32'(i), 1'b0);
      rd_chk(OFS_LOCK_DATA, (i < 4) ? 32'hffffffff : 32'h0, 1'b0);
    end
    for (int i = 0; i < OTP_RANDOM_WORDS; i++) begin
      wr_chk(OFS_IDX, 32'(i), 1'b0);
      rd_chk(OFS_OTP_DATA, OTP_HEAD[i*32 +: 32], 1'b0);
    end
    wr_chk(OFS_IDX, 32'h4, 1'b0);
    rd_chk(OFS_OTP_DATA, 32'hffffffff, 1'b0);
    wr_chk(OFS_IDX, 32'hff, 1'b0);
    rd_chk(OFS_OTP_DATA, 32'hffffffff, 1'b0);
  endtask

  task automatic test_reload;
    wr_chk(OFS_NV_CFG, 32'h5a0c3e12, 1'b0);
    wr_chk(OFS_NV_CR4, 32'hffffff7e, 1'b0);
    rd_chk(OFS_VOL_CFG, 32'h00080000, 1'b0);
    wr_chk(OFS_CTRL, 32'h1, 1'b0);
    rd_chk(OFS_STATUS, 32'h00000001, 1'b0);
    rd_chk(OFS_VOL_CFG, 32'h5a0c3e12, 1'b0);
    rd_chk(OFS_VOL_CR4, 32'h0000007e, 1'b0);
  endtask

  task automatic test_refuse;
    rd_chk(8'h3c, 32'h0, 1'b1);
    wr_chk(OFS_MAP_HDR, 32'h0, 1'b1);
    rd_chk(OFS_MAP_HDR, 32'hff0005ff, 1'b0);
    wr_chk(OFS_PROT, 32'h0, 1'b1);
    rd_chk(OFS_PROT, 32'h0000ffff, 1'b0);
  endtask

  // second reset in mid-run brings delivery values back
  task automatic test_rereset;
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    chk32(prdata, 32'h0);
    chk_err(pready, 1'b0);
    chk_err(pslverr, 1'b0);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(OFS_VOL_CFG, 32'h00080000, 1'b0);
    rd_chk(OFS_NV_CR4, 32'h00000010, 1'b0);
    // lane merge on the copies: only strobed lanes change
    wr_lane_chk(OFS_NV_CFG, 32'h11223344, 4'h2, 1'b0);
    rd_chk(OFS_NV_CFG, 32'h00083300, 1'b0);
    wr_lane_chk(OFS_NV_CR4, 32'h00000055, 4'he, 1'b0);
    rd_chk(OFS_NV_CR4, 32'h00000010, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic wrap_up;
    if (fail_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // watchdog against a hung bus
  initial begin
    repeat (5000) @(posedge pclk);
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up();
  end

  // main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    test_map();
    test_defaults();
    test_windows();
    test_reload();
    test_refuse();
    test_rereset();
    wrap_up();
  end
endmodule
